// ---- pwm_axil_slave.sv ----
// AXI4-Lite handshake engine; the register decode lives in the parent
module pwm_axil_slave
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read channels
  input wire logic arvalid,
  output logic arready,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Register side
  output logic wr_go,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_go,
  input wire logic [31:0] rd_value,
  input wire logic rd_ok
);

  logic have_aw_reg;
  logic have_w_reg;
  logic have_aw_next;
  logic have_w_next;
  logic bvalid_next;
  logic rvalid_next;
  logic aw_take;
  logic w_take;

  // Address and data are taken in either order, then written together
  always_comb
  begin
    aw_take = awvalid && awready;
    w_take = wvalid && wready;
    wr_go = have_aw_reg && have_w_reg && !bvalid;
    have_aw_next = (have_aw_reg || aw_take) && !wr_go;
    have_w_next = (have_w_reg || w_take) && !wr_go;
    bvalid_next = wr_go || (bvalid && !bready);
    rd_go = arvalid && arready;
    rvalid_next = rd_go || (rvalid && !rready);
  end

  // Write side state; readies stay low until the response is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      have_aw_reg <= 1'b0;
      have_w_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end
    else if (ce)
    begin
      have_aw_reg <= have_aw_next;
      have_w_reg <= have_w_next;
      awready <= !have_aw_next && !bvalid_next;
      wready <= !have_w_next && !bvalid_next;
      bvalid <= bvalid_next;
      if (wr_go)
        bresp <= wr_ok ? pwm_event_pkg::RESP_OKAY : pwm_event_pkg::RESP_SLVERR;
      if (aw_take)
        wr_addr <= awaddr;
      if (w_take)
      begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
    end
  end

  // Read side: data is captured when the address is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end
    else if (ce)
    begin
      arready <= !rvalid_next;
      rvalid <= rvalid_next;
      if (rd_go)
      begin
        rdata <= rd_value;
        rresp <= rd_ok ? pwm_event_pkg::RESP_OKAY : pwm_event_pkg::RESP_SLVERR;
      end
    end
  end

endmodule : pwm_axil_slave

// ---- pwm_event_irq_trigger_select_tb_top.sv ----
// Bench for the event routing block, register access over AXI4-Lite
module pwm_event_irq_trigger_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, trigger, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ce;
  logic [5:0] ev;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int pulses, fail_count, n_compared, cyc;

  pwm_event_select i_dut (.CLK(clk), .RST(rst), .CE(ce),
    .EV_COUNT_ZERO(ev[0]), .EV_COUNT_LOAD(ev[1]), .EV_CMP_A_UP(ev[2]),
    .EV_CMP_A_DOWN(ev[3]), .EV_CMP_B_UP(ev[4]), .EV_CMP_B_DOWN(ev[5]),
    .TRIGGER(trigger), .IRQ(irq), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
    .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
    .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp));
  pwm_trig_sink i_sink (.clk(clk), .rst(rst), .trig(trigger), .pulses(pulses));

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard, well above the few hundred cycles the tests take
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (!aw_done && awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (!w_done && wready) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk({30'h0, rs}, {30'h0, er});
    if (er == pwm_event_pkg::RESP_OKAY)
      chk(rd, exp);
  endtask : rd_chk

  // One cycle of event inputs, then the trigger is judged cycle by cycle
  task automatic fire(input logic [5:0] b, input logic exp_trig);
    int c0;
    c0 = pulses;
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 6'h00;
    #1 chk({31'h0, trigger}, {31'h0, exp_trig});
    @(posedge clk);
    #1 chk({31'h0, trigger}, 32'h0);
    chk(pulses - c0, {31'h0, exp_trig});
  endtask : fire

  task automatic t_reset_and_reserved();
    rd_chk(pwm_event_pkg::ENABLE_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
    // Read-modify-write keeps the reserved bits as they were read
    wr(pwm_event_pkg::ENABLE_OFFSET, rd | 32'h00003f3f, pwm_event_pkg::RESP_OKAY);
    rd_chk(pwm_event_pkg::ENABLE_OFFSET, 32'h00003f3f, pwm_event_pkg::RESP_OKAY);
    rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
  endtask : t_reset_and_reserved

  // Each event alone: only its own enables let it through
  task automatic t_each_event();
    for (int i = 0; i < 6; i++)
    begin
      wr(pwm_event_pkg::ENABLE_OFFSET, (32'h1 << (8 + i)) | (32'h1 << i),
         pwm_event_pkg::RESP_OKAY);
      fire(6'h3f ^ (6'h01 << i), 1'b0);
      rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      fire(6'h01 << i, 1'b1);
      rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h1 << i, pwm_event_pkg::RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      wr(pwm_event_pkg::STATUS_OFFSET, 32'h1 << i, pwm_event_pkg::RESP_OKAY);
      rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
    end
  endtask : t_each_event

  task automatic t_merge();
    wr(pwm_event_pkg::ENABLE_OFFSET, 32'h00003f00, pwm_event_pkg::RESP_OKAY);
    fire(6'h3f, 1'b1);
    fire(6'h14, 1'b1);
  endtask : t_merge

  // Latched bit stays when its enable is dropped, but the line goes quiet
  task automatic t_mask();
    wr(pwm_event_pkg::ENABLE_OFFSET, 32'h00000001, pwm_event_pkg::RESP_OKAY);
    fire(6'h01, 1'b0);
    chk({31'h0, irq}, 32'h1);
    wr(pwm_event_pkg::ENABLE_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
    rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h1, pwm_event_pkg::RESP_OKAY);
    rd_chk(pwm_event_pkg::STATUS_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(pwm_event_pkg::RAW_OFFSET, 32'h1, pwm_event_pkg::RESP_SLVERR);
    rd_chk(12'h100, 32'h0, pwm_event_pkg::RESP_SLVERR);
    wr(pwm_event_pkg::STATUS_OFFSET, 32'h1, pwm_event_pkg::RESP_OKAY);
    rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
  endtask : t_mask

  // An event held across a clear keeps its status bit: the set wins
  task automatic t_set_wins();
    wr(pwm_event_pkg::ENABLE_OFFSET, 32'h00000002, pwm_event_pkg::RESP_OKAY);
    @(posedge clk);
    ev <= 6'h02;
    wr(pwm_event_pkg::STATUS_OFFSET, 32'h00000002, pwm_event_pkg::RESP_OKAY);
    ev <= 6'h00;
    rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h2, pwm_event_pkg::RESP_OKAY);
    wr(pwm_event_pkg::STATUS_OFFSET, 32'h00000002, pwm_event_pkg::RESP_OKAY);
    rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
  endtask : t_set_wins

  // Clock enable low: an event is ignored, nothing triggers or latches
  task automatic t_ce_freeze();
    wr(pwm_event_pkg::ENABLE_OFFSET, 32'h00000101, pwm_event_pkg::RESP_OKAY);
    @(posedge clk);
    ce <= 1'b0;
    fire(6'h01, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    fire(6'h01, 1'b1);
    rd_chk(pwm_event_pkg::STATUS_OFFSET, 32'h1, pwm_event_pkg::RESP_OKAY);
  endtask : t_ce_freeze

  // Reset in mid-run clears the outputs and every register
  task automatic t_reset_mid();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({30'h0, trigger, irq}, 32'h0);
    rst <= 1'b0;
    rd_chk(pwm_event_pkg::ENABLE_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
    rd_chk(pwm_event_pkg::RAW_OFFSET, 32'h0, pwm_event_pkg::RESP_OKAY);
  endtask : t_reset_mid

  // Main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    ev = 6'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    fail_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset_and_reserved();
    t_each_event();
    t_merge();
    t_mask();
    t_set_wins();
    t_ce_freeze();
    t_reset_mid();
    final_report();
  end
endmodule : pwm_event_irq_trigger_select_tb_top

// ---- pwm_event_latch.sv ----
// Sticky event bits; a set in the same cycle as a clear wins
module pwm_event_latch
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Set and clear per bit
  input wire logic [5:0] set_bits,
  input wire logic [5:0] clr_bits,
  // Latched state
  output logic [5:0] q
);

  genvar i;
  generate
    for (i = 0; i < pwm_event_pkg::NUM_EVENTS; i++)
    begin : g_bit
      // Set has priority so an event arriving during a clear is kept
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          q[i] <= pwm_event_pkg::STATUS_RESET[i];
        else if (ce)
        begin
          if (set_bits[i])
            q[i] <= 1'b1; // R12
          else if (clr_bits[i])
            q[i] <= 1'b0; // R12
        end
      end
    end
  endgenerate

endmodule : pwm_event_latch

// ---- pwm_event_pkg.sv ----
// Functional notes
// R01 - With the comparator B up-count trigger enable set, a counter match on B while counting up emits a trigger pulse; cleared, it emits none.
// R02 - Enable bit 11 gates a trigger pulse on a comparator A match while counting down.
// R03 - Enable bit 10 gates a trigger pulse on a comparator A match while counting up.
// R04 - Enable bit 9 gates a trigger pulse on counter equal to load, bit 8 on counter equal to zero.
// R05 - Enable bit 5 gates the raw interrupt source for a comparator B match while counting down.
// R06 - Enable bit 4 gates the raw interrupt source for a comparator B match while counting up.
// R07 - Enable bit 3 gates the raw interrupt source for a comparator A match while counting down.
// R08 - Enable bit 2 gates the raw interrupt source for a comparator A match while counting up.
// R09 - Enable bit 1 gates the raw interrupt on counter equal to load, bit 0 on counter equal to zero.
// R10 - Software must not rely on reserved bits 7 to 6 and keeps them unchanged in read-modify-write.
// R11 - Any mix of enabled trigger events is merged onto the one trigger output with no source indication.
// R12 - Each enabled interrupt event latches a raw status bit, cleared by writing 1 to its status-and-clear bit.
// R13 - Each trigger pulse lasts exactly one clock cycle and follows the enabled match.
// R14 - The interrupt line is high while any latched status bit is set together with its enable bit.
package pwm_event_pkg;

  // Register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] ENABLE_OFFSET = 12'h044;
  localparam logic [11:0] RAW_OFFSET = 12'h048;
  localparam logic [11:0] STATUS_OFFSET = 12'h04c;

  // Event index, equal to the interrupt enable bit position
  localparam int NUM_EVENTS = 6;
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_A_UP = 2;
  localparam int EV_A_DOWN = 3;
  localparam int EV_B_UP = 4;
  localparam int EV_B_DOWN = 5;

  // Field positions in the enable register
  localparam int IRQ_EN_LSB = 0;
  localparam int TRIG_EN_LSB = 8;
  localparam logic [31:0] ENABLE_WRITE_MASK = 32'h00003f3f;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [5:0] STATUS_RESET = 6'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pwm_event_pkg

// ---- pwm_event_select.sv ----
// Routes PWM counter events to the converter trigger and the interrupt
module pwm_event_select
(
  // Clock, reset and clock enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Counter events, one-cycle pulses from the counter logic
  input wire logic EV_COUNT_ZERO,
  input wire logic EV_COUNT_LOAD,
  input wire logic EV_CMP_A_UP,
  input wire logic EV_CMP_A_DOWN,
  input wire logic EV_CMP_B_UP,
  input wire logic EV_CMP_B_DOWN,
  // Converter trigger and interrupt
  output logic TRIGGER,
  output logic IRQ,
  // AXI4-Lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [11:0] AWADDR,
  input wire logic [2:0] AWPROT,
  // AXI4-Lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read address
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [11:0] ARADDR,
  input wire logic [2:0] ARPROT,
  // AXI4-Lite read data
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP
);

  logic [31:0] event_irq_trigger_enable_reg;
  logic [31:0] enable_next;
  logic [31:0] strb_mask;
  logic [5:0] ev_vec;
  logic [5:0] irq_en;
  logic [5:0] trig_en;
  logic [5:0] raw_status;
  logic [5:0] raw_set;
  logic [5:0] raw_clr;
  logic [5:0] masked_status;
  logic wr_go;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic wr_enable_hit;
  logic wr_status_hit;
  logic rd_go;
  logic [31:0] rd_value;
  logic rd_ok;

  // Gather the event pulses in enable-bit order
  always_comb
  begin
    ev_vec = '0;
    ev_vec[pwm_event_pkg::EV_ZERO] = EV_COUNT_ZERO;
    ev_vec[pwm_event_pkg::EV_LOAD] = EV_COUNT_LOAD;
    ev_vec[pwm_event_pkg::EV_A_UP] = EV_CMP_A_UP;
    ev_vec[pwm_event_pkg::EV_A_DOWN] = EV_CMP_A_DOWN;
    ev_vec[pwm_event_pkg::EV_B_UP] = EV_CMP_B_UP;
    ev_vec[pwm_event_pkg::EV_B_DOWN] = EV_CMP_B_DOWN;
  end

  // Enable fields
  assign irq_en = event_irq_trigger_enable_reg[pwm_event_pkg::IRQ_EN_LSB +: 6];
  assign trig_en = event_irq_trigger_enable_reg[pwm_event_pkg::TRIG_EN_LSB +: 6];

  // Bus protocol engine
  pwm_axil_slave u_bus
  (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .awaddr(AWADDR),
    .wvalid(WVALID),
    .wready(WREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .bvalid(BVALID),
    .bready(BREADY),
    .bresp(BRESP),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rvalid(RVALID),
    .rready(RREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .wr_go(wr_go),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_go(rd_go),
    .rd_value(rd_value),
    .rd_ok(rd_ok)
  );

  // Write decode; the raw register is read-only so a write there is refused
  always_comb
  begin
    strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wr_enable_hit = wr_go && (wr_addr == pwm_event_pkg::ENABLE_OFFSET);
    wr_status_hit = wr_go && (wr_addr == pwm_event_pkg::STATUS_OFFSET);
    wr_ok = (wr_addr == pwm_event_pkg::ENABLE_OFFSET) ||
            (wr_addr == pwm_event_pkg::STATUS_OFFSET);
    enable_next = ((event_irq_trigger_enable_reg & ~strb_mask) | (wr_data & strb_mask)) &
                  pwm_event_pkg::ENABLE_WRITE_MASK;
  end

  // Enable register; reserved bits are never stored, so they read zero
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      event_irq_trigger_enable_reg <= pwm_event_pkg::ENABLE_RESET;
    else if (CE && wr_enable_hit)
      event_irq_trigger_enable_reg <= enable_next; // R10
  end

  // Only enabled events latch; write-one clears the status-and-clear view
  always_comb
  begin
    raw_set = ev_vec & irq_en; // R05 R06 R07 R08 R09 R12
    raw_clr = wr_status_hit && wr_strb[0] ? wr_data[5:0] : 6'h00; // R12
  end

  // Sticky raw interrupt status
  pwm_event_latch u_raw
  (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .set_bits(raw_set),
    .clr_bits(raw_clr),
    .q(raw_status)
  );

  // Status seen by the controller is the raw status under its enable
  assign masked_status = raw_status & irq_en;

  // Read decode, captured by the slave when the address is taken
  always_comb
  begin
    rd_value = 32'h00000000;
    rd_ok = 1'b1;
    unique case (ARADDR)
      pwm_event_pkg::ENABLE_OFFSET: rd_value = event_irq_trigger_enable_reg;
      pwm_event_pkg::RAW_OFFSET: rd_value = {26'h0000000, raw_status};
      pwm_event_pkg::STATUS_OFFSET: rd_value = {26'h0000000, masked_status};
      default: rd_ok = 1'b0;
    endcase
  end

  // Trigger is registered so the pin is glitch free; it costs one cycle of latency
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      TRIGGER <= 1'b0;
    else if (CE)
      TRIGGER <= |(ev_vec & trig_en); // R01 R02 R03 R04 R11 R13
  end

  // Level interrupt follows the masked latched status
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      IRQ <= 1'b0;
    else if (CE)
      IRQ <= |masked_status; // R14
  end

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_trig_b_up: // R01
  assert property (CE && EV_CMP_B_UP && trig_en[pwm_event_pkg::EV_B_UP] |=> TRIGGER)
    else $error("B up match with trigger enabled gave no trigger");

  a_trig_a_down: // R02
  assert property (CE && EV_CMP_A_DOWN && trig_en[pwm_event_pkg::EV_A_DOWN] |=> TRIGGER)
    else $error("A down match with trigger enabled gave no trigger");

  a_trig_a_up: // R03
  assert property (CE && EV_CMP_A_UP && trig_en[pwm_event_pkg::EV_A_UP] |=> TRIGGER)
    else $error("A up match with trigger enabled gave no trigger");

  a_trig_load_zero: // R04
  assert property (CE && ((EV_COUNT_LOAD && trig_en[pwm_event_pkg::EV_LOAD]) ||
                   (EV_COUNT_ZERO && trig_en[pwm_event_pkg::EV_ZERO])) |=> TRIGGER)
    else $error("Load or zero match with trigger enabled gave no trigger");

  a_trig_no_cause: // R11
  assert property (CE && ((ev_vec & trig_en) == 6'h00) |=> !TRIGGER)
    else $error("Trigger without an enabled event");

  a_trig_one_cycle: // R13
  assert property (CE && TRIGGER && ((ev_vec & trig_en) == 6'h00) ##1 CE |-> !TRIGGER)
    else $error("Trigger pulse longer than one cycle");

  a_raw_b_down: // R05
  assert property (CE && EV_CMP_B_DOWN |=> raw_status[5] == $past(irq_en[5]) || $past(raw_status[5]))
    else $error("B down raw status does not follow its enable");

  a_raw_b_up: // R06
  assert property (CE && EV_CMP_B_UP && irq_en[4] |=> raw_status[4])
    else $error("B up raw status not latched");

  a_raw_a_down: // R07
  assert property (CE && !raw_status[3] && !(EV_CMP_A_DOWN && irq_en[3]) |=> !raw_status[3])
    else $error("A down raw status set without an enabled event");

  a_raw_a_up: // R08
  assert property ((CE && EV_CMP_A_UP && irq_en[2]) ##1 (CE && !raw_clr[2])
                   |=> raw_status[2])
    else $error("A up raw status not held");

  a_raw_load_zero: // R09
  assert property (CE && ((EV_COUNT_LOAD && irq_en[1]) || (EV_COUNT_ZERO && irq_en[0]))
                   |=> raw_status[1] || raw_status[0])
    else $error("Load or zero raw status not latched");

  a_status_clear: // R12
  assert property (CE && raw_clr[0] && !raw_set[0] |=> !raw_status[0])
    else $error("Write one did not clear the zero status");

  a_set_wins: // R12
  assert property (CE && raw_clr[1] && raw_set[1] |=> raw_status[1])
    else $error("Event lost against a clear");

  a_irq_level: // R14
  assert property (CE |=> IRQ == |$past(masked_status))
    else $error("Interrupt line does not follow enabled status");

  a_trig_b_down: // R11
  assert property (CE && EV_CMP_B_DOWN && trig_en[pwm_event_pkg::EV_B_DOWN] |=> TRIGGER)
    else $error("B down match with trigger enabled gave no trigger");

  a_raw_hold: // R12
  assert property (CE && (raw_set == 6'h00) && (raw_clr == 6'h00) |=> raw_status == $past(raw_status))
    else $error("Raw status changed without an event or a clear");

  a_clear_any: // R12
  assert property (CE |=> (raw_status & $past(raw_clr) & ~$past(raw_set)) == 6'h00)
    else $error("Write one left a status bit set");

  a_enable_write: // R10
  assert property (CE && wr_enable_hit && (wr_strb == 4'hf)
                   |=> event_irq_trigger_enable_reg ==
                       ($past(wr_data) & pwm_event_pkg::ENABLE_WRITE_MASK))
    else $error("Enable register does not hold the written fields");

  // Clock enable low freezes every register, so events arriving while it is low are lost
  a_freeze_trig: // R13
  assert property (!CE |=> $stable(TRIGGER))
    else $error("Trigger moved while the clock enable was low");

  a_freeze_raw: // R12
  assert property (!CE |=> $stable(raw_status))
    else $error("Raw status moved while the clock enable was low");

  a_freeze_irq: // R14
  assert property (!CE |=> $stable(IRQ))
    else $error("Interrupt moved while the clock enable was low");

  a_freeze_enable: // R10
  assert property (!CE |=> $stable(event_irq_trigger_enable_reg))
    else $error("Enable register moved while the clock enable was low");

  // Bus handshake order: one write and one read in flight at most
  a_aw_taken:
  assert property (CE && AWVALID && AWREADY |=> !AWREADY)
    else $error("Write address ready stayed high after a take");

  a_w_taken:
  assert property (CE && WVALID && WREADY |=> !WREADY)
    else $error("Write data ready stayed high after a take");

  a_aw_blocked:
  assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("Write readies high while a response is pending");

  a_ar_blocked:
  assert property (RVALID |-> !ARREADY)
    else $error("Read address ready high while read data is pending");

  a_b_single:
  assert property (CE && BVALID && BREADY |=> !BVALID)
    else $error("Write response repeated after its handshake");

  a_r_single:
  assert property (CE && RVALID && RREADY |=> !RVALID)
    else $error("Read data repeated after its handshake");

endmodule : pwm_event_select

// ---- pwm_trig_sink.sv ----
// Converter sequencer stand-in: counts one conversion start per high trigger cycle
module pwm_trig_sink
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Trigger from the block
  input wire logic trig,
  // Conversions started so far
  output int pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  // A stretched pulse shows up as extra starts, which the bench then catches
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pulses <= 0;
    else if (trig)
      pulses <= pulses + 1;
  end
endmodule : pwm_trig_sink
